// ==== rtl/incr_defines.svh ====
`ifndef INCR_DEFINES_SVH
`define INCR_DEFINES_SVH

// Instruction word layout
`define INSTR_W          14
`define OPC_HI           13
`define OPC_LO           8
`define DEST_BIT         7
`define FIDX_HI          6
`define FIDX_LO          0
`define LIT_HI           7
`define LIT_LO           0

// Six-bit opcode field values
`define OPC_INC_SKIP     6'h0f
`define OPC_INC          6'h0a
`define OPC_OR_LIT       6'h38

// Destination choice: 1 sends the result back to the register
`define DEST_TO_REG      1'h1

// Reset values
`define ACC_RST          8'h00
`define ZERO_RST         1'h0
`define FIDX_RST         7'h00

// Increment step, wraps in 8 bits
`define INC_STEP         8'h01

`endif

// ==== rtl/incr_pkg.sv ====
package incr_pkg;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_EXEC  = 2'b01,
    ST_NOP_A = 2'b10,
    ST_NOP_B = 2'b11
  } seq_state_t;

  // Recognised operations
  typedef enum logic [1:0] {
    OP_NONE     = 2'b00,
    OP_INC_SKIP = 2'b01,
    OP_INC      = 2'b10,
    OP_OR_LIT   = 2'b11
  } op_t;

  // Decoded instruction
  typedef struct packed {
    op_t        op;
    logic       dest;
    logic [6:0] fidx;
    logic [7:0] lit;
  } decoded_t;

  // Register file write port
  typedef struct packed {
    logic       we;
    logic [7:0] data;
  } reg_write_t;

  // Zero flag update port
  typedef struct packed {
    logic we;
    logic value;
  } zero_update_t;

  // Whole module state
  typedef struct packed {
    seq_state_t   state;
    decoded_t     instr;
    logic         ready;
    logic [6:0]   reg_addr;
    reg_write_t   reg_wr;
    logic [7:0]   acc;
    zero_update_t zero;
    logic         flush;
    logic         done;
  } core_state_t;

endpackage : incr_pkg

// ==== rtl/incr_exec.sv ====
`timescale 1ns/1ps
`include "incr_defines.svh"
// Notes on behaviour
// - Decode increment-skip; leave status flags untouched
// - Destination bit: 0 accumulator, 1 register
// - Zero result on skip discards next, two cycles
// - Decode plain increment; one cycle; update zero
// - OR literal into accumulator; update zero flag
//
// Timing outline: a word is taken in the address slot, the register
// file answers combinationally from REG_ADDR_OUT during the execute
// slot, and all results appear together one clock later. A skip on a
// null result adds two clocks of no-op, during which READY_OUT stays
// low so the fetch side cannot hand over the word that was dropped.
module incr_exec (
  input  wire logic                  CLK_IN,
  input  wire logic                  RSTN_IN,
  input  wire logic                  INSTR_VALID_IN,
  input  wire logic [13:0]           INSTR_IN,
  input  wire logic [7:0]            REG_RDATA_IN,
  input  wire logic                  ACC_LOAD_IN,
  input  wire logic [7:0]            ACC_LOAD_DATA_IN,
  output logic                       READY_OUT,
  output logic [6:0]                 REG_ADDR_OUT,
  output incr_pkg::reg_write_t       REG_WR_OUT,
  output logic [7:0]                 ACC_OUT,
  output incr_pkg::zero_update_t     ZERO_OUT,
  output logic                       FLUSH_OUT,
  output logic                       DONE_OUT
);
  import incr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // Maps a raw word onto one of the three handled operations, or OP_NONE
  // Operand fields are copied for every word; only the opcode decides
  // whether the block takes it, so unused fields cost nothing here
  function automatic decoded_t decode_word(input logic [13:0] word);
    decoded_t dec;
    dec.dest = word[`DEST_BIT];
    dec.fidx = word[`FIDX_HI:`FIDX_LO];
    dec.lit  = word[`LIT_HI:`LIT_LO];
    unique case (word[`OPC_HI:`OPC_LO])
      `OPC_INC_SKIP: dec.op = OP_INC_SKIP;
      `OPC_INC:      dec.op = OP_INC;
      `OPC_OR_LIT:   dec.op = OP_OR_LIT;
      default:       dec.op = OP_NONE;
    endcase
    return dec;
  endfunction : decode_word

  // Eight-bit increment; the carry out is dropped on purpose
  function automatic logic [7:0] incr8(input logic [7:0] value);
    logic [8:0] sum;
    sum = {1'b0, value} + {1'b0, `INC_STEP};
    return sum[7:0];
  endfunction : incr8

  ////////////////////////////////////////////////////////////////////////////
  // State

  core_state_t cur_q;
  core_state_t nxt_d;
  decoded_t    dec_in;
  logic [7:0]  result;
  logic        result_null;

  // Word decode is pure combinational on the input
  assign dec_in = decode_word(INSTR_IN);

  // Result of the operation held in the execute slot
  // Read data is only meaningful in the execute slot; the value
  // computed in other states is never registered
  always_comb begin
    unique case (cur_q.instr.op)
      OP_INC_SKIP, OP_INC: result = incr8(REG_RDATA_IN);
      OP_OR_LIT:           result = cur_q.acc | cur_q.instr.lit;
      default:             result = REG_RDATA_IN;
    endcase
  end

  // Null test on the full 8-bit result
  assign result_null = (result == 8'h00);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  // One instruction cycle is two clocks: address slot, then execute slot
  // Every strobe is cleared by default so that a state that forgets one
  // cannot leave a write pulse standing for more than a clock
  always_comb begin
    nxt_d        = cur_q;
    // Strobes last one clock only
    nxt_d.reg_wr.we = 1'b0;
    nxt_d.zero.we   = 1'b0;
    nxt_d.flush     = 1'b0;
    nxt_d.done      = 1'b0;
    nxt_d.ready     = 1'b0;

    // Outside loads of the accumulator; own writes below take priority
    if (ACC_LOAD_IN) begin
      nxt_d.acc = ACC_LOAD_DATA_IN;
    end

    unique case (cur_q.state)
      ST_IDLE: begin
        // Take only on the registered ready, so the fetch side and the
        // block agree on the edge that accepts the word
        nxt_d.ready = 1'b1;
        // Words of other instructions are left to other units
        if (INSTR_VALID_IN && cur_q.ready && dec_in.op != OP_NONE) begin
          nxt_d.instr    = dec_in;
          nxt_d.reg_addr = dec_in.fidx;
          nxt_d.state    = ST_EXEC;
          nxt_d.ready    = 1'b0;
        end
      end

      ST_EXEC: begin
        // All results of the held word leave together in this slot
        nxt_d.done = 1'b1;
        unique case (cur_q.instr.op)
          OP_INC_SKIP: begin
            // Status flags stay as they are for this form
            nxt_d.zero.we = 1'b0;
            if (cur_q.instr.dest == `DEST_TO_REG) begin
              nxt_d.reg_wr.we   = 1'b1;
              nxt_d.reg_wr.data = result;
            end else begin
              nxt_d.acc = result;
            end
            if (result_null) begin
              // Drop the prefetched word and burn one cycle as a no-op
              nxt_d.flush = 1'b1;
              nxt_d.state = ST_NOP_A;
            end else begin
              nxt_d.state = ST_IDLE;
              nxt_d.ready = 1'b1;
            end
          end
          OP_INC: begin
            // Same data path as the skip form, but the zero flag moves
            if (cur_q.instr.dest == `DEST_TO_REG) begin
              nxt_d.reg_wr.we   = 1'b1;
              nxt_d.reg_wr.data = result;
            end else begin
              nxt_d.acc = result;
            end
            nxt_d.zero.we    = 1'b1;
            nxt_d.zero.value = result_null;
            nxt_d.state      = ST_IDLE;
            nxt_d.ready      = 1'b1;
          end
          OP_OR_LIT: begin
            // Literal form never touches the register file
            nxt_d.acc        = result;
            nxt_d.zero.we    = 1'b1;
            nxt_d.zero.value = result_null;
            nxt_d.state      = ST_IDLE;
            nxt_d.ready      = 1'b1;
          end
          default: begin
            // Cannot be held here; recover to idle
            nxt_d.done  = 1'b0;
            nxt_d.state = ST_IDLE;
            nxt_d.ready = 1'b1;
          end
        endcase
      end

      // Two clocks of no-op stand in for the discarded word
      ST_NOP_A: begin
        nxt_d.state = ST_NOP_B;
      end

      ST_NOP_B: begin
        nxt_d.state = ST_IDLE;
        nxt_d.ready = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  // Synchronous reset to constants only
  // Ready comes up one clock after release, which keeps the first word
  // away from the edge on which reset is still being seen
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      cur_q.state       <= ST_IDLE;
      cur_q.instr.op    <= OP_NONE;
      cur_q.instr.dest  <= 1'b0;
      cur_q.instr.fidx  <= `FIDX_RST;
      cur_q.instr.lit   <= 8'h00;
      cur_q.ready       <= 1'b0;
      cur_q.reg_addr    <= `FIDX_RST;
      cur_q.reg_wr      <= '0;
      cur_q.acc         <= `ACC_RST;
      cur_q.zero.we     <= 1'b0;
      cur_q.zero.value  <= `ZERO_RST;
      cur_q.flush       <= 1'b0;
      cur_q.done        <= 1'b0;
    end else begin
      cur_q <= nxt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from the state register
  // No output logic sits after the register, so callers see clean
  // levels and pulses with a full clock of settling time

  assign READY_OUT    = cur_q.ready;
  assign REG_ADDR_OUT = cur_q.reg_addr; // Held after the write for the file
  assign REG_WR_OUT   = cur_q.reg_wr;
  assign ACC_OUT      = cur_q.acc;
  assign ZERO_OUT     = cur_q.zero;
  assign FLUSH_OUT    = cur_q.flush;
  assign DONE_OUT     = cur_q.done;

endmodule : incr_exec

// ==== test/incr_exec_chk.sv ====
`timescale 1ns/1ps
module incr_exec_chk (
  input wire logic                   CLK_IN,
  input wire logic                   RSTN_IN,
  input wire logic                   INSTR_VALID_IN,
  input wire logic [13:0]            INSTR_IN,
  input wire logic [7:0]             REG_RDATA_IN,
  input wire logic                   READY_OUT,
  input wire incr_pkg::reg_write_t   REG_WR_OUT,
  input wire logic [7:0]             ACC_OUT,
  input wire incr_pkg::zero_update_t ZERO_OUT,
  input wire logic                   FLUSH_OUT,
  input wire logic                   DONE_OUT
);
  import incr_pkg::*;
  logic [5:0] opc;
  logic       take;
  logic       inc;
  // Accepted word of one of the three handled opcodes
  assign opc  = INSTR_IN[13:8];
  assign inc  = opc == 6'h0f || opc == 6'h0a;
  assign take = READY_OUT && INSTR_VALID_IN && (inc || opc == 6'h38);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  //////////////////////////////////////////////////////////////////////
  property p_done; take |-> ##2 DONE_OUT; endproperty
  a_done: assert property (p_done) else $error("done late");
  property p_skz; take && opc == 6'h0f |-> ##2 !ZERO_OUT.we; endproperty
  a_skz: assert property (p_skz) else $error("skip touched zero");
  property p_incz;
    take && opc == 6'h0a |-> ##2 ZERO_OUT.we && ZERO_OUT.value == ($past(REG_RDATA_IN) == 8'hff);
  endproperty
  a_incz: assert property (p_incz) else $error("inc zero wrong");
  property p_dreg;
    take && inc && INSTR_IN[7] |-> ##2 REG_WR_OUT.we && REG_WR_OUT.data == $past(REG_RDATA_IN) + 8'h01;
  endproperty
  a_dreg: assert property (p_dreg) else $error("reg write wrong");
  property p_dacc;
    take && inc && !INSTR_IN[7] |-> ##2 !REG_WR_OUT.we && ACC_OUT == $past(REG_RDATA_IN) + 8'h01;
  endproperty
  a_dacc: assert property (p_dacc) else $error("acc write wrong");
  property p_fl;
    take && opc == 6'h0f |-> ##2 FLUSH_OUT == ($past(REG_RDATA_IN) == 8'hff);
  endproperty
  a_fl: assert property (p_fl) else $error("flush wrong");
  property p_rdy; FLUSH_OUT |-> !READY_OUT ##1 !READY_OUT ##1 READY_OUT; endproperty
  a_rdy: assert property (p_rdy) else $error("skip slot wrong");
  property p_or;
    take && opc == 6'h38 |-> ##2 ZERO_OUT.we && ACC_OUT == ($past(ACC_OUT, 2) | $past(INSTR_IN[7:0], 2));
  endproperty
  a_or: assert property (p_or) else $error("or wrong");
  // Main scenarios reached
  c_fl: cover property (take ##2 FLUSH_OUT);
  c_or: cover property (take && opc == 6'h38);
  c_z: cover property (ZERO_OUT.we && ZERO_OUT.value);
endmodule : incr_exec_chk
bind incr_exec incr_exec_chk incr_exec_chk_i (.CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN),
  .INSTR_VALID_IN(INSTR_VALID_IN), .INSTR_IN(INSTR_IN), .REG_RDATA_IN(REG_RDATA_IN),
  .READY_OUT(READY_OUT), .REG_WR_OUT(REG_WR_OUT), .ACC_OUT(ACC_OUT), .ZERO_OUT(ZERO_OUT),
  .FLUSH_OUT(FLUSH_OUT), .DONE_OUT(DONE_OUT));

// ==== test/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import incr_pkg::*;
  logic         CLK_IN, RSTN_IN, INSTR_VALID_IN, ACC_LOAD_IN, READY_OUT, FLUSH_OUT, DONE_OUT;
  logic [13:0]  INSTR_IN;
  logic [7:0]   REG_RDATA_IN, ACC_LOAD_DATA_IN, ACC_OUT, e_acc;
  logic [6:0]   REG_ADDR_OUT;
  reg_write_t   REG_WR_OUT;
  zero_update_t ZERO_OUT;
  int           fails, check_count;
  // Word then register read data
  logic [21:0]  rows [8] = '{22'h0f05ff, 22'h380000, 22'h389a00, 22'h383500,
                             22'h0a7f7f, 22'h0a81ff, 22'h0f8210, 22'h0fffff};
  incr_exec incr_exec_i (.CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN), .INSTR_VALID_IN(INSTR_VALID_IN),
    .INSTR_IN(INSTR_IN), .REG_RDATA_IN(REG_RDATA_IN), .ACC_LOAD_IN(ACC_LOAD_IN),
    .ACC_LOAD_DATA_IN(ACC_LOAD_DATA_IN), .READY_OUT(READY_OUT), .REG_ADDR_OUT(REG_ADDR_OUT),
    .REG_WR_OUT(REG_WR_OUT), .ACC_OUT(ACC_OUT), .ZERO_OUT(ZERO_OUT), .FLUSH_OUT(FLUSH_OUT),
    .DONE_OUT(DONE_OUT));
  //////////////////////////////////////////////////////////////////////
  task chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task tally_and_finish;
    if (fails == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  // One instruction, expectations from the bench's own accumulator
  task exec(input logic [13:0] w, input logic [7:0] rd);
    logic [7:0] r;
    logic       lit, we;
    r = rd + 8'h01;
    lit = w[13:8] == 6'h38;
    we = !lit && w[7];
    for (int n = 0; n < 8 && READY_OUT !== 1'b1; n++) @(negedge CLK_IN);
    INSTR_VALID_IN = 1'b1;
    INSTR_IN = w;
    REG_RDATA_IN = rd;
    @(negedge CLK_IN);
    INSTR_VALID_IN = 1'b0;
    if (!lit) chk(REG_ADDR_OUT, w[6:0]);
    @(negedge CLK_IN);
    if (lit) e_acc = e_acc | w[7:0];
    else if (!w[7]) e_acc = r;
    chk({DONE_OUT, FLUSH_OUT, READY_OUT}, {1'b1, w[13:8] == 6'h0f && r == 0, !(w[13:8] == 6'h0f && r == 0)});
    chk({REG_WR_OUT.we, REG_WR_OUT.data & {8{REG_WR_OUT.we}}}, {we, r & {8{we}}});
    chk(ACC_OUT, e_acc);
    chk({ZERO_OUT.we, ZERO_OUT.value & ZERO_OUT.we},
        w[13:8] == 6'h0f ? 2'b00 : {1'b1, (lit ? e_acc : r) == 8'h00});
  endtask : exec
  // Clock, 25 ns period
  initial begin
    CLK_IN = 1'b0;
    forever #12.5 CLK_IN = ~CLK_IN;
  end
  // Watchdog, about nineteen times the expected run
  initial begin
    #20000;
    fails++;
    tally_and_finish;
  end
  // Main sequence
  initial begin
    RSTN_IN = 1'b0;
    INSTR_VALID_IN = 1'b0;
    INSTR_IN = 14'h0000;
    REG_RDATA_IN = 8'h00;
    ACC_LOAD_IN = 1'b0;
    ACC_LOAD_DATA_IN = 8'h00;
    e_acc = 8'h00;
    repeat (16) @(negedge CLK_IN);
    chk({READY_OUT, DONE_OUT, ACC_OUT}, 10'h000);
    RSTN_IN = 1'b1;
    for (int i = 0; i < 8; i++) exec(rows[i][21:8], rows[i][7:0]);
    // Outside load, then OR on top of it
    ACC_LOAD_IN = 1'b1;
    ACC_LOAD_DATA_IN = 8'h40;
    @(negedge CLK_IN);
    ACC_LOAD_IN = 1'b0;
    e_acc = 8'h40;
    chk(ACC_OUT, e_acc);
    exec(14'h3803, 8'h00);
    // Decrement-skip word must be left alone
    INSTR_IN = 14'h0b05;
    INSTR_VALID_IN = 1'b1;
    repeat (3) begin
      @(negedge CLK_IN);
      chk({DONE_OUT, READY_OUT}, 2'b01);
    end
    INSTR_VALID_IN = 1'b0;
    tally_and_finish;
  end
endmodule : testbench
